// ==== rtl/csl_pkg.sv ====
/*
 * Constants and types shared by the clock stop and strap latch block.
 * Assumes a single 20 MHz master clock from which all outputs are divided.
 */
package csl_pkg;
    // output group widths
    localparam int PROC_W = 4;
    localparam int GBUS_W = 6;
    localparam int STRAP_W = 5;
    // timing
    localparam int MCLK_PERIOD_NS = 50;
    localparam int PWRUP_TIME_MS = 3;
    // longest time: rounds down
    localparam int PWRUP_CYCLES = (PWRUP_TIME_MS * 1000000) / MCLK_PERIOD_NS;
    localparam int TMR_W = 16;
    localparam int DIV_W = 2;
    // values after reset
    localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
    localparam logic GATE_EN_RST = 1'h1;
    localparam logic [STRAP_W-1:0] CFG_RST = 5'h1f;
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b00,
        ST_HOLD = 2'b01,
        ST_TOGGLE = 2'b10
    } csl_strap_st_t;
endpackage : csl_pkg

// ==== rtl/csl_strap_if.sv ====
/*
 * Carrier between the top and the strap latch.
 * Assumes both ends sit on the same master clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface csl_strap_if;
    logic nxt_bus_phase;
    logic [csl_pkg::STRAP_W-1:0] cfg;
    logic done;
    modport strap (input nxt_bus_phase, output cfg, output done);
    modport core (output nxt_bus_phase, input cfg, input done);
endinterface : csl_strap_if
`default_nettype wire

// ==== rtl/csl_clk_gate.sv ====
/*
 * Glitch-free gate for a group of divided clock outputs.
 * Assumes the run request is synchronous to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module csl_clk_gate #(
    parameter int N = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // control
    input wire logic nxt_phase_in,
    input wire logic run_in,
    // gated clocks
    output logic [N-1:0] clk_out
);
    logic en_ff;
    logic nxt_en;
    logic [N-1:0] out_ff;
    logic [N-1:0] nxt_out;

    // the enable only moves on edges where the output is low next,
    // so a stop or restart can never clip a pulse
    always_comb
    begin
        nxt_en = nxt_phase_in ? en_ff : run_in;
        nxt_out = {N{nxt_en & nxt_phase_in}};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            en_ff <= csl_pkg::GATE_EN_RST;
            out_ff <= '0;
        end
        else if (ce_in)
        begin
            en_ff <= nxt_en;
            out_ff <= nxt_out;
        end
    end

    assign clk_out = out_ff;
endmodule : csl_clk_gate
`default_nettype wire

// ==== rtl/csl_strap_latch.sv ====
/*
 * Strap capture at power-on, then strap pins as outputs held low until the
 * power-up timer expires, after which they toggle.
 * Assumes rstn_in is the power-on reset, released once the supply is good.
 */
`timescale 1ns/100ps
`default_nettype none
module csl_strap_latch #(
    parameter int PWRUP_CYCLES = csl_pkg::PWRUP_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // strap pins
    input wire logic [csl_pkg::STRAP_W-1:0] strap_in,
    output logic [csl_pkg::STRAP_W-1:0] strap_out,
    output logic [csl_pkg::STRAP_W-1:0] strap_oe_out,
    // to the core
    csl_strap_if.strap sif
);
    localparam logic [csl_pkg::TMR_W-1:0] PWRUP_LAST = csl_pkg::TMR_W'(PWRUP_CYCLES - 1);
    csl_pkg::csl_strap_st_t st_ff, nxt_st;
    logic [csl_pkg::STRAP_W-1:0] cfg_ff, nxt_cfg, out_ff, nxt_out, oe_ff, nxt_oe;
    logic [csl_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cfg = cfg_ff;
        nxt_tmr = tmr_ff;
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        unique case (st_ff)
            csl_pkg::ST_CAPTURE:
            begin
                nxt_cfg = strap_in;
                nxt_oe = {csl_pkg::STRAP_W{1'b1}};
                nxt_out = '0;
                nxt_st = csl_pkg::ST_HOLD;
            end
            csl_pkg::ST_HOLD:
            begin
                nxt_out = '0;
                if (tmr_ff == PWRUP_LAST)
                    nxt_st = csl_pkg::ST_TOGGLE;
                else
                    nxt_tmr = csl_pkg::TMR_W'(tmr_ff + 1'b1);
            end
            csl_pkg::ST_TOGGLE:
                nxt_out = {csl_pkg::STRAP_W{sif.nxt_bus_phase}};
            // an upset state must not recapture the straps
            default:
                nxt_st = csl_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            st_ff <= csl_pkg::ST_CAPTURE;
            cfg_ff <= csl_pkg::CFG_RST;
            tmr_ff <= csl_pkg::TMR_RST;
            out_ff <= '0;
            oe_ff <= '0;
        end
        else if (ce_in)
        begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
            tmr_ff <= nxt_tmr;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign strap_out = out_ff;
    assign strap_oe_out = oe_ff;
    assign sif.cfg = cfg_ff;
    assign sif.done = (st_ff != csl_pkg::ST_CAPTURE);

    a_hold_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (st_ff == csl_pkg::ST_HOLD) |-> (out_ff == '0) && (oe_ff == '1))
        else $error("strap outputs not held low before timer end");
endmodule : csl_strap_latch
`default_nettype wire

// ==== rtl/csl_top.sv ====
/*
 * Clock stop and strap latch: divides the master clock into processor,
 * gated bus and free-running bus clocks, stops the processor and gated bus
 * groups on their active-low halt inputs, and latches power-on straps.
 * Assumes halt inputs change only after a rising edge of the free-running
 * bus clock, and that the pin model pulls undriven straps high.
 */
`timescale 1ns/100ps
`default_nettype none
// Contract
// - processor halt low stops processor clocks
// - bus halt low stops six gated clocks
// - processor halt leaves other clocks running
// - bus halt leaves other clocks running
// - processor clocks stop low, full restart pulse
// - gated bus clocks stop low, full pulse
// - processor stop/start latency under two periods
// - gated bus latency under one period
// - straps are inputs, captured at power-good
// - after capture straps drive low
// - power-up timer then straps toggle
// - straps captured only once at power-on
// - undriven strap reads as one
module csl_top #(
    parameter int PWRUP_CYCLES = csl_pkg::PWRUP_CYCLES
) (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // halt requests
    input wire logic proc_halt_n_in,
    input wire logic bus_halt_n_in,
    // clock outputs
    output logic [csl_pkg::PROC_W-1:0] processor_clock_out,
    output logic [csl_pkg::GBUS_W-1:0] gated_bus_clock_out,
    output logic free_running_bus_clock_out,
    // dual-function pins
    input wire logic [csl_pkg::STRAP_W-1:0] strap_in,
    output logic [csl_pkg::STRAP_W-1:0] strap_out,
    output logic [csl_pkg::STRAP_W-1:0] strap_oe_out,
    // latched configuration
    output logic [csl_pkg::STRAP_W-1:0] config_out
);
    logic [csl_pkg::DIV_W-1:0] div_ff;
    logic [csl_pkg::DIV_W-1:0] nxt_div;
    logic free_ff;
    logic nxt_free;
    logic [csl_pkg::STRAP_W-1:0] cfg_ff;
    logic [csl_pkg::STRAP_W-1:0] nxt_cfg;
    logic nxt_proc_phase;
    logic nxt_bus_phase;
    csl_strap_if sif ();

    function automatic logic [csl_pkg::DIV_W-1:0] div_step(input logic [csl_pkg::DIV_W-1:0] cur);
        div_step = csl_pkg::DIV_W'(cur + 1'b1);
    endfunction : div_step

    // one divider feeds every group so the stopped groups never lose phase
    // against the free-running ones; processor clock is half the master,
    // bus clocks a quarter
    always_comb
    begin
        nxt_div = div_step(div_ff);
        nxt_proc_phase = nxt_div[0];
        nxt_bus_phase = nxt_div[1];
        nxt_free = nxt_bus_phase;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            div_ff <= csl_pkg::DIV_RST;
            free_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            div_ff <= nxt_div;
            free_ff <= nxt_free;
        end
    end

    assign free_running_bus_clock_out = free_ff;

    // halt inputs are already synchronous; the gate enable flop is the
    // only stage, which keeps latency inside the allowed window
    csl_clk_gate #(
        .N(csl_pkg::PROC_W)
    ) u_proc_gate (
        .clk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .nxt_phase_in(nxt_proc_phase),
        .run_in(proc_halt_n_in),
        .clk_out(processor_clock_out)
    );

    csl_clk_gate #(
        .N(csl_pkg::GBUS_W)
    ) u_bus_gate (
        .clk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .nxt_phase_in(nxt_bus_phase),
        .run_in(bus_halt_n_in),
        .clk_out(gated_bus_clock_out)
    );

    assign sif.nxt_bus_phase = nxt_bus_phase;

    csl_strap_latch #(
        .PWRUP_CYCLES(PWRUP_CYCLES)
    ) u_strap (
        .clk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .strap_in(strap_in),
        .strap_out(strap_out),
        .strap_oe_out(strap_oe_out),
        .sif(sif)
    );

    // registered copy so the configuration port comes from a flop
    always_comb
    begin
        nxt_cfg = sif.done ? sif.cfg : cfg_ff;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            cfg_ff <= csl_pkg::CFG_RST;
        else if (ce_in)
            cfg_ff <= nxt_cfg;
    end

    assign config_out = cfg_ff;

    // checks; they stop looking while the clock enable freezes the block
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in || !ce_in);

    logic past_valid_ff;
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            past_valid_ff <= 1'b0;
        else
            past_valid_ff <= 1'b1;
    end

    sequence s_proc_halted;
        !proc_halt_n_in [*2];
    endsequence

    sequence s_proc_running;
        proc_halt_n_in [*3];
    endsequence

    sequence s_bus_halted;
        !bus_halt_n_in [*3];
    endsequence

    sequence s_bus_running;
        bus_halt_n_in [*3];
    endsequence

    sequence s_free_rise;
        $rose(free_ff);
    endsequence

    a_proc_stop_low: assert property (s_proc_halted |=> processor_clock_out == '0)
        else $error("processor clocks not stopped low");

    a_proc_latency: assert property ($fell(proc_halt_n_in) ##1 !proc_halt_n_in |-> ##1 processor_clock_out == '0)
        else $error("processor clocks stopped too late");

    a_proc_restart: assert property (past_valid_ff && $rose(proc_halt_n_in) ##0 proc_halt_n_in [*3]
        |-> ##[1:3] processor_clock_out == '1)
        else $error("processor clocks restarted too late");

    a_proc_full_pulse: assert property ($rose(processor_clock_out[0])
        |-> $past(nxt_proc_phase) && processor_clock_out == '1)
        else $error("processor pulse out of phase");

    a_bus_stop_low: assert property (s_bus_halted ##1 !bus_halt_n_in |-> gated_bus_clock_out == '0)
        else $error("gated bus clocks not stopped low");

    a_bus_full_pulse: assert property ($rose(gated_bus_clock_out[0]) |=> gated_bus_clock_out[0] ##1 !gated_bus_clock_out[0])
        else $error("gated bus pulse clipped");

    a_bus_restart: assert property (s_free_rise ##0 bus_halt_n_in ##1 s_bus_running
        |-> ##[0:2] gated_bus_clock_out == {csl_pkg::GBUS_W{free_ff}})
        else $error("gated bus clocks resumed too late");

    a_bus_in_step: assert property (gated_bus_clock_out[0] |-> free_ff && gated_bus_clock_out == '1)
        else $error("gated bus clock out of step with free clock");

    a_free_period: assert property (past_valid_ff ##0 s_free_rise |=> free_ff ##1 !free_ff ##1 !free_ff ##1 free_ff)
        else $error("free-running bus clock period wrong");

    // three running samples first, so a restart still under way cannot trip it
    a_proc_runs_on: assert property (!bus_halt_n_in ##0 s_proc_running ##1 proc_halt_n_in
        |-> processor_clock_out[0] != $past(processor_clock_out[0]))
        else $error("processor clocks disturbed by bus halt");

    a_bus_runs_on: assert property (!proc_halt_n_in ##0 s_bus_running ##1 bus_halt_n_in
        |-> gated_bus_clock_out[0] == free_ff)
        else $error("bus clocks disturbed by processor halt");

    a_strap_capture: assert property (past_valid_ff && $rose(strap_oe_out[0]) |-> sif.cfg == $past(strap_in))
        else $error("strap capture does not match pins");

    a_strap_once: assert property (sif.done |=> $stable(sif.cfg) && $stable(strap_oe_out))
        else $error("strap configuration changed after capture");

    a_cfg_follow: assert property (sif.done |=> config_out == $past(sif.cfg))
        else $error("configuration output lags capture");

    a_strap_toggle: assert property (strap_out[0] |-> strap_oe_out[0] && free_ff)
        else $error("strap output high outside toggle phase");

    // the bus halt input only changes with a free clock rise, one flop late
    a_halt_sync: assert property (past_valid_ff && $changed(bus_halt_n_in) |-> $past(nxt_free) && !$past(free_ff))
        else $error("bus halt changed off the free clock rise");
endmodule : csl_top
`default_nettype wire

// ==== sim/csl_pm_model.sv ====
/*
 * Power management controller model and strap pin model for the bench.
 * Assumes the free bus clock comes from the device and that requests from the
 * bench are levels that the model passes on at the next free clock rise.
 */
`timescale 1ns/100ps
`default_nettype none
module csl_pm_model (
    // master clock from the bench, free clock from the device
    input wire logic mclk_in,
    input wire logic free_clk_in,
    // stop requests from the bench
    input wire logic proc_stop_req_in,
    input wire logic bus_stop_req_in,
    // board and device side of the strap pins
    input wire logic [csl_pkg::STRAP_W-1:0] board_en_in,
    input wire logic [csl_pkg::STRAP_W-1:0] board_val_in,
    input wire logic [csl_pkg::STRAP_W-1:0] strap_out_in,
    input wire logic [csl_pkg::STRAP_W-1:0] strap_oe_in,
    // to the device
    output logic proc_halt_n_out,
    output logic bus_halt_n_out,
    output logic [csl_pkg::STRAP_W-1:0] strap_pin_out
);
    logic free_prev;

    initial
    begin
        proc_halt_n_out = 1'h1;
        bus_halt_n_out = 1'h1;
        free_prev = 1'h0;
    end

    // halts move only just after a free clock rise, never in between
    always @(negedge mclk_in)
    begin
        if (free_clk_in === 1'h1 && free_prev === 1'h0)
        begin
            proc_halt_n_out <= ~proc_stop_req_in;
            bus_halt_n_out <= ~bus_stop_req_in;
        end
        free_prev <= free_clk_in;
    end

    // device drive wins; a released and undriven pin floats up
    always_comb
    begin
        for (int i = 0; i < csl_pkg::STRAP_W; i++)
            strap_pin_out[i] = strap_oe_in[i] ? strap_out_in[i] : (board_en_in[i] ? board_val_in[i] : 1'h1);
    end
endmodule : csl_pm_model
`default_nettype wire

// ==== sim/tb_clock_stop_and_strap_latch.sv ====
/*
 * Self-checking bench for the clock stop and strap latch top.
 * Assumes the partner model passes halt requests on at free clock rises.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_clock_stop_and_strap_latch;
    localparam int PWRUP = 12;
    localparam int CEILING = 2000;
    logic mclk, rstn, ce, proc_req, bus_req, proc_halt_n, bus_halt_n, fclk;
    logic [csl_pkg::PROC_W-1:0] pclk;
    logic [csl_pkg::GBUS_W-1:0] gclk;
    logic [csl_pkg::STRAP_W-1:0] pin, sout, soe, cfg, bd_en, bd_val;
    int mismatches, compares, cycles;

    csl_top #(.PWRUP_CYCLES(PWRUP)) DUT (.mclk_in(mclk), .rstn_in(rstn), .ce_in(ce),
        .proc_halt_n_in(proc_halt_n), .bus_halt_n_in(bus_halt_n), .processor_clock_out(pclk),
        .gated_bus_clock_out(gclk), .free_running_bus_clock_out(fclk), .strap_in(pin),
        .strap_out(sout), .strap_oe_out(soe), .config_out(cfg));

    csl_pm_model partner (.mclk_in(mclk), .free_clk_in(fclk), .proc_stop_req_in(proc_req),
        .bus_stop_req_in(bus_req), .board_en_in(bd_en), .board_val_in(bd_val), .strap_out_in(sout),
        .strap_oe_in(soe), .proc_halt_n_out(proc_halt_n), .bus_halt_n_out(bus_halt_n), .strap_pin_out(pin));

    always #25 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == CEILING)
        begin
            mismatches = mismatches + 1;
            conclude();
        end
    end

    task automatic conclude();
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // counts over n falling edges: highs per group, torn groups, gated and strap following free
    task automatic watch(input int n, output int p, output int g, output int f, output int m, output int e,
        output int sf);
        p = 0; g = 0; f = 0; m = 0; e = 0; sf = 0;
        repeat (n)
        begin
            @(negedge mclk);
            p += int'(pclk === '1);
            g += int'(gclk === '1);
            f += int'(fclk === 1'h1);
            m += int'((pclk !== '1 && pclk !== '0) || (gclk !== '1 && gclk !== '0));
            e += int'(gclk === {csl_pkg::GBUS_W{fclk}});
            sf += int'(sout === {csl_pkg::STRAP_W{fclk}});
        end
    endtask : watch

    task automatic t_straps();
        int p, g, f, m, e, sf, k;
        check("cfg in reset", 8'(cfg), 8'h1f);
        check("pclk in reset", 8'(pclk), 8'h00);
        rstn = 1'h1;
        @(negedge mclk);
        check("oe after capture", 8'(soe), 8'h1f);
        check("out after capture", 8'(sout), 8'h00);
        @(negedge mclk);
        check("cfg captured", 8'(cfg), 8'h1a);
        k = 0;
        repeat (PWRUP - 2)
        begin
            @(negedge mclk);
            k += int'(sout !== 5'h00);
        end
        check("straps held low", 8'(k), 8'h00);
        repeat (4) @(negedge mclk);
        watch(8, p, g, f, m, e, sf);
        check("straps follow", 8'(sf), 8'h08);
        check("straps rise", 8'(f), 8'h04);
    endtask : t_straps

    task automatic t_proc_halt();
        int p, g, f, m, e, sf, k;
        proc_req = 1'h1;
        k = 0;
        while (proc_halt_n !== 1'h0 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        repeat (4) @(negedge mclk);
        watch(12, p, g, f, m, e, sf);
        check("pclk halted", 8'(p), 8'h00);
        check("gclk runs", 8'(g), 8'h06);
        check("fclk runs", 8'(f), 8'h06);
        check("groups whole", 8'(m), 8'h00);
        proc_req = 1'h0;
        k = 0;
        while (proc_halt_n !== 1'h1 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        k = 0;
        while (pclk !== '1 && k < 3)
        begin
            @(negedge mclk);
            k++;
        end
        check("pclk restart", 8'(pclk), 8'h0f);
        @(negedge mclk);
        check("pclk first low", 8'(pclk), 8'h00);
        @(negedge mclk);
        check("pclk second high", 8'(pclk), 8'h0f);
    endtask : t_proc_halt

    task automatic t_bus_halt();
        int p, g, f, m, e, sf, k;
        bus_req = 1'h1;
        k = 0;
        while (bus_halt_n !== 1'h0 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        repeat (4) @(negedge mclk);
        watch(12, p, g, f, m, e, sf);
        check("gclk halted", 8'(g), 8'h00);
        check("pclk runs", 8'(p), 8'h06);
        check("fclk runs", 8'(f), 8'h06);
        check("groups whole", 8'(m), 8'h00);
        bus_req = 1'h0;
        k = 0;
        while (bus_halt_n !== 1'h1 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        k = 0;
        while (gclk !== '1 && k < 4)
        begin
            @(negedge mclk);
            k++;
        end
        check("gclk resume", 8'(gclk), 8'h3f);
        watch(8, p, g, f, m, e, sf);
        check("gclk full pulses", 8'(e), 8'h08);
    endtask : t_bus_halt

    // clock enable low must freeze the processor clock outputs; only pclk is checked
    task automatic t_freeze();
        int k;
        logic [csl_pkg::PROC_W-1:0] held;
        held = pclk;
        ce = 1'h0;
        k = 0;
        repeat (4)
        begin
            @(negedge mclk);
            k += int'(pclk !== held);
        end
        check("pclk frozen", 8'(k), 8'h00);
        ce = 1'h1;
        @(negedge mclk);
    endtask : t_freeze

    initial
    begin
        mclk = 1'h0;
        rstn = 1'h0;
        ce = 1'h1;
        proc_req = 1'h0;
        bus_req = 1'h0;
        bd_en = 5'h07;
        bd_val = 5'h02;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(negedge mclk);
        t_straps();
        t_proc_halt();
        t_bus_halt();
        t_freeze();
        check("cfg kept", 8'(cfg), 8'h1a);
        conclude();
    end
endmodule : tb_clock_stop_and_strap_latch
`default_nettype wire
